// File: src/arb_waveform_loader.sv
// Byte FIFO and waveform loader with APB registers
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[AW-1:0]];
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) wr_q <= wr_q + 1'b1;
      if (out_valid && out_ready) rd_q <= rd_q + 1'b1;
    end
  end
endmodule

module arb_waveform_loader
  import arb_loader_pkg::*;
#(
  parameter int RX_DEPTH = FIFO_DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  input  wire logic [15:0] wave_rd_addr,
  output logic      [15:0] wave_rd_data,
  output wave_status_type  wave_status
);
  initial begin
    if (RX_DEPTH < 2) $error("RX_DEPTH too small");
  end

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_LIST = 7'h02,
    S_HASH = 7'h04,
    S_NDIG = 7'h08,
    S_LEN  = 7'h10,
    S_DATA = 7'h20,
    S_COPY = 7'h40
  } state_type;

  function automatic logic [7:0] upcase(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction

  function automatic logic [95:0] name_high_byte_first(input logic [95:0] raw, input logic [4:0] len);
    logic [95:0] n;
    n = '0;
    for (int i = 0; i < 12; i++) begin
      if (5'(i) < len) n[95-8*i -: 8] = upcase(raw[95-8*i -: 8]);
    end
    return n;
  endfunction

  function automatic err_type name_check(input logic [95:0] n, input logic [4:0] len);
    logic [7:0] c;
    logic       bad;
    bad = 1'b0;
    for (int i = 0; i < 12; i++) begin
      c = n[95-8*i -: 8];
      if (5'(i) < len) begin
        if (c < 8'h41 || c > 8'h5a) begin
          if (i == 0 || !((c >= 8'h30 && c <= 8'h39) || c == 8'h5f)) bad = 1'b1;
        end
      end
    end
    if (len > NAME_MAX) return ERR_TOO_LONG;
    if (len == 5'h00 || bad) return ERR_NAME;
    return ERR_NONE;
  endfunction

  function automatic logic [15:0] map_index(input logic [15:0] a, input logic [16:0] n);
    logic [32:0] p;
    p = 33'(a) * 33'(n);
    return (n <= 17'(SHORT_IMAGE)) ? p[29:14] : p[31:16];
  endfunction

  logic [15:0] scratch_mem [0:MAX_POINTS-1];
  logic [15:0] slot_mem [0:SLOTS*MAX_POINTS-1];

  state_type   state_q;
  mode_type    mode_q;
  logic        swap_q;
  err_type     err_q;
  logic [16:0] cnt_q;
  logic [16:0] pts_q;
  logic [31:0] byte_cnt_q;
  logic [3:0]  ndig_q;
  logic [7:0]  first_q;
  logic        half_q;
  logic [95:0] name_q;
  logic [4:0]  name_len_q;
  logic [3:0]  slot_used_q;
  logic [95:0] slot_name_q [0:SLOTS-1];
  logic [16:0] slot_cnt_q [0:SLOTS-1];
  logic [1:0]  copy_slot_q;
  logic [16:0] copy_idx_q;
  logic [3:0]  active_q;
  logic [3:0]  out_code_q;
  logic        output_on_q;

  logic        f_valid;
  logic [7:0]  f_data;
  logic        f_ready;
  logic        take;
  logic        wr;
  logic        mapped;
  logic [7:0]  digit;
  logic        is_digit;
  logic [15:0] block_pt;
  logic        block_ok;
  logic signed [47:0] fprod;
  logic [15:0] list_pt;
  logic        list_ok;
  logic [95:0] high_byte_first;
  err_type     name_err;
  logic        builtin_hit;
  logic [4:0]  hit_slot;
  logic [4:0]  free_slot;
  logic [31:0] len_next;
  err_type     new_err;

  byte_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) rx_fifo (
    .clk       (core_clk),
    .rst       (rst),
    .in_valid  (rx_valid),
    .in_data   (rx_data),
    .in_ready  (rx_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_ready)
  );

  // Bytes wait in the FIFO until a block download is armed, so the host is stalled
  assign f_ready  = state_q inside {S_HASH, S_NDIG, S_LEN, S_DATA};
  assign take     = f_valid && f_ready;
  assign wr       = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign mapped   = paddr inside {ADDR_CTRL, ADDR_CFG, ADDR_DATA, ADDR_STATUS, ADDR_NAME0, ADDR_NAME1,
                                  ADDR_NAME2, ADDR_NAMELEN, ADDR_SAVE, ADDR_SELECT, ADDR_ERROR, ADDR_COUNT};
  assign pslverr  = psel && penable && !mapped;
  assign digit    = f_data - 8'h30;
  assign is_digit = f_data >= 8'h30 && f_data <= 8'h39;
  assign len_next = 32'(byte_cnt_q * 32'd10) + 32'(digit);
  assign block_pt = swap_q ? {f_data, first_q} : {first_q, f_data};
  assign block_ok = $signed(block_pt) <= 16'sh07ff && $signed(block_pt) >= -16'sh07ff;
  assign fprod    = 48'($signed(pwdata)) * 48'(INT_PEAK);
  assign high_byte_first     = name_high_byte_first(name_q, name_len_q);
  assign name_err = name_check(high_byte_first, name_len_q);

  always_comb begin
    if (mode_q == MODE_FLOAT) begin
      list_ok = $signed(pwdata) <= FLOAT_ONE && $signed(pwdata) >= -FLOAT_ONE;
      list_pt = 16'(fprod >>> FLOAT_FRAC);
    end else begin
      list_ok = $signed(pwdata) <= INT_PEAK && $signed(pwdata) >= -INT_PEAK;
      list_pt = pwdata[15:0];
    end
  end

  always_comb begin
    builtin_hit = 1'b0;
    hit_slot    = 5'h10;
    free_slot   = 5'h10;
    for (int i = 0; i < BUILTINS; i++) begin
      if (high_byte_first == BUILTIN_NAMES[i]) builtin_hit = 1'b1;
    end
    for (int k = SLOTS-1; k >= 0; k--) begin
      if (slot_used_q[k] && slot_name_q[k] == high_byte_first) hit_slot = 5'(k);
      if (!slot_used_q[k]) free_slot = 5'(k);
    end
  end

  // Errors found this cycle; a new error wins over a clearing write
  always_comb begin
    new_err = ERR_NONE;
    if (wr && paddr == ADDR_DATA && (state_q != S_LIST || !list_ok || cnt_q == 17'(MAX_POINTS))) begin
      new_err = ERR_CMD;
    end
    if (wr && paddr == ADDR_CTRL && pwdata[CTRL_FINISH_BIT] && state_q == S_LIST && cnt_q == '0) begin
      new_err = ERR_CMD;
    end
    if (take) begin
      case (state_q)
        S_HASH: if (f_data != 8'h23) new_err = ERR_CMD;
        S_NDIG: if (!is_digit || digit == 8'h00) new_err = ERR_CMD;
        S_LEN: begin
          if (!is_digit) begin
            new_err = ERR_CMD;
          end else if (ndig_q == 4'h1 && (len_next[0] || len_next == '0 || len_next > 32'(2*MAX_POINTS))) begin
            new_err = ERR_CMD;
          end
        end
        S_DATA: if (half_q && !block_ok) new_err = ERR_CMD;
        default: ;
      endcase
    end
    if (wr && paddr == ADDR_SAVE && state_q == S_IDLE) begin
      if (pwdata[1:0] != 2'h0 || pwdata[SAVE_DEST_BIT]) new_err = ERR_COPY;
      else if (name_err != ERR_NONE) new_err = name_err;
      else if (builtin_hit) new_err = ERR_BUILTIN;
      else if (pts_q == '0) new_err = ERR_NOT_EXIST;
      else if (hit_slot[4] && free_slot[4]) new_err = ERR_NO_MEM;
    end
    if (wr && paddr == ADDR_SELECT && !pwdata[SEL_GO_BIT]) begin
      if (pwdata[3:0] == SEL_SCRATCH && pts_q == '0) new_err = ERR_NOT_EXIST;
      if (pwdata[3:0] == SEL_BY_NAME && hit_slot[4]) new_err = ERR_NOT_EXIST;
      if (pwdata[3:0] > SEL_BY_NAME) new_err = ERR_CMD;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      err_q <= ERR_NONE;
    end else if (new_err != ERR_NONE) begin
      err_q <= new_err;
    end else if (wr && paddr == ADDR_ERROR) begin
      err_q <= ERR_NONE;
    end
  end

  // Download, header parse and copy sequencing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q     <= S_IDLE;
      mode_q      <= MODE_FLOAT;
      cnt_q       <= '0;
      pts_q       <= '0;
      byte_cnt_q  <= '0;
      ndig_q      <= '0;
      first_q     <= '0;
      half_q      <= 1'b0;
      copy_slot_q <= '0;
      copy_idx_q  <= '0;
    end else if (new_err != ERR_NONE && state_q != S_IDLE) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (wr && paddr == ADDR_CTRL && pwdata[CTRL_START_BIT]) begin
            mode_q  <= mode_type'(pwdata[1:0]);
            pts_q   <= '0;
            cnt_q   <= '0;
            state_q <= (pwdata[1:0] == MODE_BLOCK) ? S_HASH : S_LIST;
          end else if (wr && paddr == ADDR_SAVE && new_err == ERR_NONE) begin
            copy_slot_q <= hit_slot[4] ? free_slot[1:0] : hit_slot[1:0];
            copy_idx_q  <= '0;
            state_q     <= S_COPY;
          end
        end
        S_LIST: begin
          if (wr && paddr == ADDR_DATA) begin
            cnt_q <= cnt_q + 17'h00001;
          end else if (wr && paddr == ADDR_CTRL && pwdata[CTRL_FINISH_BIT]) begin
            pts_q   <= cnt_q;
            state_q <= S_IDLE;
          end
        end
        S_HASH: if (take) state_q <= S_NDIG;
        S_NDIG: begin
          if (take) begin
            ndig_q     <= digit[3:0];
            byte_cnt_q <= '0;
            state_q    <= S_LEN;
          end
        end
        S_LEN: begin
          if (take) begin
            byte_cnt_q <= len_next;
            ndig_q     <= ndig_q - 4'h1;
            half_q     <= 1'b0;
            if (ndig_q == 4'h1) state_q <= S_DATA;
          end
        end
        S_DATA: begin
          if (take) begin
            half_q  <= !half_q;
            first_q <= f_data;
            if (half_q) begin
              cnt_q      <= cnt_q + 17'h00001;
              byte_cnt_q <= byte_cnt_q - 32'd2;
              if (byte_cnt_q == 32'd2) begin
                pts_q   <= cnt_q + 17'h00001;
                state_q <= S_IDLE;
              end
            end
          end
        end
        S_COPY: begin
          copy_idx_q <= copy_idx_q + 17'h00001;
          if (copy_idx_q == pts_q - 17'h00001) state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (state_q == S_LIST && wr && paddr == ADDR_DATA && new_err == ERR_NONE) begin
      scratch_mem[cnt_q[15:0]] <= list_pt;
    end
    if (state_q == S_DATA && take && half_q && block_ok) begin
      scratch_mem[cnt_q[15:0]] <= block_pt;
    end
    if (state_q == S_COPY) begin
      slot_mem[{copy_slot_q, copy_idx_q[15:0]}] <= scratch_mem[copy_idx_q[15:0]];
    end
  end

  // Slot directory; a slot becomes visible only once its copy has finished
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slot_used_q <= '0;
      for (int k = 0; k < SLOTS; k++) begin
        slot_name_q[k] <= '0;
        slot_cnt_q[k]  <= '0;
      end
    end else if (state_q == S_COPY && copy_idx_q == pts_q - 17'h00001) begin
      slot_used_q[copy_slot_q] <= 1'b1;
      slot_name_q[copy_slot_q] <= high_byte_first;
      slot_cnt_q[copy_slot_q]  <= pts_q;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      swap_q     <= RESET_SWAP;
      name_q     <= '0;
      name_len_q <= '0;
    end else if (wr) begin
      if (paddr == ADDR_CFG) swap_q <= pwdata[0];
      if (paddr == ADDR_NAME0) name_q[95:64] <= pwdata;
      if (paddr == ADDR_NAME1) name_q[63:32] <= pwdata;
      if (paddr == ADDR_NAME2) name_q[31:0] <= pwdata;
      if (paddr == ADDR_NAMELEN) name_len_q <= pwdata[4:0];
    end
  end

  // Selection only names the waveform; the go bit latches it onto the output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active_q    <= SEL_SCRATCH;
      out_code_q  <= SEL_SCRATCH;
      output_on_q <= 1'b0;
    end else if (wr && paddr == ADDR_SELECT && new_err == ERR_NONE) begin
      if (pwdata[SEL_GO_BIT]) begin
        out_code_q  <= active_q;
        output_on_q <= 1'b1;
      end else if (pwdata[3:0] == SEL_BY_NAME) begin
        active_q <= SEL_SLOT0 + hit_slot[3:0];
      end else begin
        active_q <= pwdata[3:0];
      end
    end
  end

  logic [16:0] out_cnt;
  logic [1:0]  out_slot;
  assign out_slot = 2'(out_code_q - SEL_SLOT0);
  assign out_cnt  = (out_code_q == SEL_SCRATCH) ? pts_q :
                    (out_code_q >= SEL_SLOT0) ? slot_cnt_q[out_slot] : '0;

  always_comb begin
    wave_status.output_on   = output_on_q;
    wave_status.active_code = out_code_q;
    wave_status.image_len   = (out_cnt <= 17'(SHORT_IMAGE)) ? 17'(SHORT_IMAGE) : 17'(MAX_POINTS);
  end

  // Factory waveforms live elsewhere, so they read back as zero here
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wave_rd_data <= '0;
    end else if (out_code_q == SEL_SCRATCH && pts_q != '0) begin
      wave_rd_data <= scratch_mem[map_index(wave_rd_addr, out_cnt)];
    end else if (out_code_q >= SEL_SLOT0) begin
      wave_rd_data <= slot_mem[{out_slot, map_index(wave_rd_addr, out_cnt)}];
    end else begin
      wave_rd_data <= '0;
    end
  end

  always_comb begin
    prdata = '0;
    case (paddr)
      ADDR_CTRL:    prdata = {30'h0, mode_q};
      ADDR_CFG:     prdata = {31'h0, swap_q};
      ADDR_STATUS:  prdata = {25'h0, slot_used_q, output_on_q, pts_q != '0, state_q != S_IDLE};
      ADDR_NAME0:   prdata = name_q[95:64];
      ADDR_NAME1:   prdata = name_q[63:32];
      ADDR_NAME2:   prdata = name_q[31:0];
      ADDR_NAMELEN: prdata = {27'h0, name_len_q};
      ADDR_SELECT:  prdata = {23'h0, output_on_q, 4'h0, active_q};
      ADDR_ERROR:   prdata = {28'h0, err_q};
      ADDR_COUNT:   prdata = {15'h0, pts_q};
      default:      prdata = '0;
    endcase
  end
endmodule
`default_nettype wire

// File: include/arb_loader_pkg.sv
// Constants and types shared by the arbitrary waveform loader
// How it works
// - Downloads hold 1 to 65,536 points; one point is a constant level.
// - Up to 16,384 points play as 16,384 entries, more as 65,536.
// - Float list values run from -1 to +1, mapped to the peak codes.
// - Integer codes run from -2047 to +2047, the 12-bit converter range.
// - Every new download silently replaces the scratch waveform.
// - Four named user slots exist apart from scratch and factory waveforms.
// - Block points are signed 16-bit, two bytes each; byte count is even.
// - High byte first by default; low byte first when swapped order is set.
// - Byte order affects only block downloads and reads back as set.
// - Save copies only scratch into a named slot, never into scratch.
// - Names: up to 12 chars, letter first, then letters, digits, underscore.
// - Saving under a factory name is refused with its own error.
// - Names are upper-cased before storing or comparing.
// - Select any factory, user or scratch waveform; a separate go outputs it.
// - A block header is parsed before data bytes are taken as points.
package arb_loader_pkg;
  localparam int                 MAX_POINTS  = 65536;
  localparam int                 SHORT_IMAGE = 16384;
  localparam logic signed [31:0] INT_PEAK    = 32'sh000007ff;
  localparam logic signed [31:0] FLOAT_ONE   = 32'sh00010000;
  localparam int                 FLOAT_FRAC  = 16;
  localparam logic [4:0]         NAME_MAX    = 5'h0c;
  localparam int                 SLOTS       = 4;
  localparam int                 BUILTINS    = 5;
  localparam int                 FIFO_DEPTH  = 16;
  localparam logic               RESET_SWAP  = 1'b0;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CFG     = 8'h04;
  localparam logic [7:0] ADDR_DATA    = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [7:0] ADDR_NAME0   = 8'h10;
  localparam logic [7:0] ADDR_NAME1   = 8'h14;
  localparam logic [7:0] ADDR_NAME2   = 8'h18;
  localparam logic [7:0] ADDR_NAMELEN = 8'h1c;
  localparam logic [7:0] ADDR_SAVE    = 8'h20;
  localparam logic [7:0] ADDR_SELECT  = 8'h24;
  localparam logic [7:0] ADDR_ERROR   = 8'h28;
  localparam logic [7:0] ADDR_COUNT   = 8'h2c;

  localparam int CTRL_START_BIT  = 4;
  localparam int CTRL_FINISH_BIT = 5;
  localparam int SAVE_DEST_BIT   = 2;
  localparam int SEL_GO_BIT      = 8;

  localparam logic [3:0] SEL_SCRATCH = 4'h5;
  localparam logic [3:0] SEL_BY_NAME = 4'h6;
  localparam logic [3:0] SEL_SLOT0   = 4'h6;

  typedef enum logic [1:0] {
    MODE_FLOAT = 2'h0,
    MODE_INT   = 2'h1,
    MODE_BLOCK = 2'h2
  } mode_type;

  typedef enum logic [3:0] {
    ERR_NONE      = 4'h0,
    ERR_CMD       = 4'h1,
    ERR_TOO_LONG  = 4'h2,
    ERR_BUILTIN   = 4'h3,
    ERR_NO_MEM    = 4'h4,
    ERR_NOT_EXIST = 4'h5,
    ERR_COPY      = 4'h6,
    ERR_NAME      = 4'h7
  } err_type;

  localparam logic [95:0] BUILTIN_NAMES [0:BUILTINS-1] = '{
    96'h4558505f5249534500000000, 96'h4558505f46414c4c00000000,
    96'h4e45475f52414d5000000000, 96'h53494e430000000000000000,
    96'h434152444941430000000000};

  typedef struct packed {
    logic        output_on;
    logic [3:0]  active_code;
    logic [16:0] image_len;
  } wave_status_type;
endpackage

// File: verification/arb_waveform_loader_checker.sv
// Port assertions for the waveform loader
`timescale 1ns/100ps
`default_nettype none
module arb_waveform_loader_checker
  import arb_loader_pkg::*;
(
  input wire logic            core_clk,
  input wire logic            rst,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            rx_valid,
  input wire logic [7:0]      rx_data,
  input wire logic            rx_ready,
  input wire logic [15:0]     wave_rd_addr,
  input wire logic [15:0]     wave_rd_data,
  input wire wave_status_type wave_status
);
  logic cfg_q;
  wire logic acc = psel && penable;
  wire logic rd = acc && !pwrite;
  wire logic go = acc && pwrite && paddr == ADDR_SELECT && pwdata[SEL_GO_BIT];
  // Shadow of the byte order so readback is checked against every write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= RESET_SWAP;
    end else if (acc && pwrite && paddr == ADDR_CFG) begin
      cfg_q <= pwdata[0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_image_len; wave_status.image_len == 17'h04000 || wave_status.image_len == 17'h10000; endproperty
  a_image_len: assert property (p_image_len) else $error("image length is neither size");
  property p_rd_range; $signed(wave_rd_data) >= -16'sd2047 && $signed(wave_rd_data) <= 16'sd2047; endproperty
  a_rd_range: assert property (p_rd_range) else $error("output point beyond peak code");
  property p_status_hold; !go |=> $stable({wave_status.output_on, wave_status.active_code}); endproperty
  a_status_hold: assert property (p_status_hold) else $error("output changed without go");
  property p_go_on; go |=> wave_status.output_on; endproperty
  a_go_on: assert property (p_go_on) else $error("go did not start output");
  property p_sel_read; rd && paddr == ADDR_SELECT |-> prdata[8] == wave_status.output_on; endproperty
  a_sel_read: assert property (p_sel_read) else $error("select readback disagrees");
  property p_cfg_read; rd && paddr == ADDR_CFG |-> prdata == {31'h0, cfg_q}; endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("byte order readback wrong");
  property p_err_read; rd && paddr == ADDR_ERROR |-> prdata < 32'h8; endproperty
  a_err_read: assert property (p_err_read) else $error("unknown error code");
  property p_count_max; rd && paddr == ADDR_COUNT |-> prdata <= 32'h10000; endproperty
  a_count_max: assert property (p_count_max) else $error("point count above maximum");
  c_go: cover property (go);
  c_full: cover property (!rx_ready);
  c_slverr: cover property (pslverr);
endmodule
`default_nettype wire

// File: verification/host_model.sv
// Remote host byte source for binary block downloads
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic rx_ready,
  input  wire logic slow,
  output logic      rx_valid,
  output logic [7:0] rx_data
);
  logic [7:0] q [$];
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // Idle data is inverted so a stale byte is never mistaken for a new one
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else if (!rx_valid || rx_ready) begin
      if (rx_valid) begin
        void'(q.pop_front());
      end
      if (q.size() != 0 && !(slow && rx_valid)) begin
        rx_valid <= 1'b1;
        rx_data  <= q[0];
      end else begin
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/arb_waveform_loader_tb.sv
// Register-level testbench for the waveform loader
`timescale 1ns/100ps
`default_nettype none
module arb_waveform_loader_tb
  import arb_loader_pkg::*;
;
  localparam int PAUSE = 25000;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, rx_valid, rx_ready, slv;
  logic [7:0] rx_data;
  logic [15:0] wave_rd_addr = 16'h0, wave_rd_data;
  wave_status_type ws;
  int failures = 0, n_checks = 0, cyc = 0;
  logic [7:0] blk [12] = '{8'h07, 8'hff, 8'hf8, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'hff, 8'h04, 8'h00};
  string bad [4] = '{"x", "#0", "#13", "#6131074"};
  always #20 core_clk = ~core_clk;
  arb_waveform_loader arb_waveform_loader_i (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .wave_rd_addr(wave_rd_addr),
    .wave_rd_data(wave_rd_data), .wave_status(ws));
  host_model host_model_i (.core_clk(core_clk), .rst(rst), .rx_ready(rx_ready), .slow(slow),
    .rx_valid(rx_valid), .rx_data(rx_data));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rdv & m) !== e && n < 300);
    chk(nm, e, rdv & m);
  endtask
  task automatic wave(input logic [15:0] a, input logic [15:0] e);
    wave_rd_addr <= a;
    repeat (2) @(posedge core_clk);
    chk("wave_rd_data", {16'h0, e}, {16'h0, wave_rd_data});
  endtask
  task automatic show();
    wr(ADDR_SELECT, 32'h5);
    wr(ADDR_SELECT, 32'h100);
  endtask
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      host_model_i.push(s[i]);
    end
  endtask
  // Error is read only once busy drops, since a save takes one cycle a point
  task automatic save_try(input logic [31:0] nm, input logic [4:0] len, input logic [2:0] cmd, input logic [3:0] e);
    wr(ADDR_NAME0, nm);
    wr(ADDR_NAMELEN, {27'h0, len});
    wr(ADDR_SAVE, {29'h0, cmd});
    poll("busy", ADDR_STATUS, 32'h1, 32'h0);
    poll("save error", ADDR_ERROR, 32'hf, {28'h0, e});
    wr(ADDR_ERROR, 32'h0);
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    poll("select", ADDR_SELECT, 32'hffffffff, 32'h5);
    chk("wave_status", {10'h0, 1'b0, 4'h5, 17'h04000}, {10'h0, ws});
    poll("cfg", ADDR_CFG, 32'hffffffff, 32'h0);
    chk("rx_ready", 32'h1, {31'h0, rx_ready});
    apb(1'b0, 8'h30, 32'h0);
    chk("pslverr", 32'h1, {31'h0, slv});
    wr(ADDR_CTRL, 32'h11);
    wr(ADDR_DATA, 32'h800);
    poll("error", ADDR_ERROR, 32'hf, 32'h1);
    wr(ADDR_ERROR, 32'h0);
    wr(ADDR_CTRL, 32'h11);
    wr(ADDR_DATA, 32'h7ff);
    wr(ADDR_DATA, 32'hfffff801);
    wr(ADDR_CTRL, 32'h21);
    poll("count", ADDR_COUNT, 32'hffffffff, 32'h2);
    show();
    chk("wave_status", {10'h0, 1'b1, 4'h5, 17'h04000}, {10'h0, ws});
    wave(16'h0000, 16'h07ff);
    wave(16'h2000, 16'hf801);
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_DATA, 32'h10001);
    poll("error", ADDR_ERROR, 32'hf, 32'h1);
    wr(ADDR_ERROR, 32'h0);
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_DATA, 32'h10000);
    wr(ADDR_DATA, 32'hffff0000);
    wr(ADDR_DATA, 32'h0);
    wr(ADDR_CTRL, 32'h20);
    poll("error", ADDR_ERROR, 32'hf, 32'h0);
    poll("count", ADDR_COUNT, 32'hffffffff, 32'h3);
    show();
    wave(16'h0000, 16'h07ff);
    wave(16'h1770, 16'hf801);
    wave(16'h3fff, 16'h0000);
    // Queue a whole block before arming so the buffer fills and refuses
    send("#212");
    for (int i = 0; i < 12; i++) begin
      host_model_i.push(blk[i]);
    end
    repeat (40) @(posedge core_clk);
    chk("rx_ready", 32'h0, {31'h0, rx_ready});
    slow <= 1'b1;
    wr(ADDR_CTRL, 32'h12);
    poll("count", ADDR_COUNT, 32'hffffffff, 32'h6);
    show();
    wave(16'h0000, 16'h07ff);
    wave(16'h0aab, 16'hf801);
    wave(16'h3fff, 16'h0400);
    wr(ADDR_CFG, 32'h1);
    poll("cfg", ADDR_CFG, 32'hffffffff, 32'h1);
    wr(ADDR_CTRL, 32'h12);
    send("#14");
    repeat (PAUSE) @(posedge core_clk);
    send(string'({8'hff, 8'h07, 8'h01, 8'hf8}));
    poll("count", ADDR_COUNT, 32'hffffffff, 32'h2);
    show();
    wave(16'h0000, 16'h07ff);
    wave(16'h2000, 16'hf801);
    slow <= 1'b0;
    save_try({"ABC", 8'h00}, 5'h03, 3'h1, 4'h6);
    save_try({"ABC", 8'h00}, 5'h03, 3'h4, 4'h6);
    save_try({"ABC", 8'h00}, 5'h0d, 3'h0, 4'h2);
    save_try({"1AB", 8'h00}, 5'h03, 3'h0, 4'h7);
    save_try({"A B", 8'h00}, 5'h03, 3'h0, 4'h7);
    save_try("sinc", 5'h04, 3'h0, 4'h3);
    for (int k = 0; k < 4; k++) begin
      save_try({"ARB", 8'(8'h30 + k)}, 5'h04, 3'h0, 4'h0);
    end
    save_try("ARB4", 5'h04, 3'h0, 4'h4);
    save_try("arb0", 5'h04, 3'h0, 4'h0);
    poll("slots", ADDR_STATUS, 32'h78, 32'h78);
    wr(ADDR_NAME0, "zz99");
    wr(ADDR_SELECT, 32'h6);
    poll("error", ADDR_ERROR, 32'hf, 32'h5);
    wr(ADDR_ERROR, 32'h0);
    wr(ADDR_NAME0, "arb1");
    wr(ADDR_SELECT, 32'h6);
    poll("select", ADDR_SELECT, 32'h10f, 32'h107);
    wr(ADDR_SELECT, 32'h100);
    chk("active_code", 32'h7, {28'h0, ws.active_code});
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_SELECT, k);
      wr(ADDR_SELECT, 32'h100);
      chk("active_code", k, {28'h0, ws.active_code});
    end
    foreach (bad[i]) begin
      wr(ADDR_CTRL, 32'h12);
      send(bad[i]);
      poll("error", ADDR_ERROR, 32'hf, 32'h1);
      wr(ADDR_ERROR, 32'h0);
    end
    tally_and_finish();
  end
endmodule
bind arb_waveform_loader arb_waveform_loader_checker arb_waveform_loader_checker_i (.core_clk(core_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
  .wave_rd_addr(wave_rd_addr), .wave_rd_data(wave_rd_data), .wave_status(wave_status));
`default_nettype wire
